// File: spbs_bridge_end.sv
// How it works
// - Address then data share one 32-bit bus
// - Initiator drives write data, target read data
// - Command in address phase, byte enables after
// - Dual address: dual command first, real second
// - Idle bus with grant: park address/command lines
// - Parity is even over 36 bits
// - Parity follows its data by one clock
// - Parity released one clock after data lines
// - Parked parity starts one clock after parking
// - Receivers check parity against sampled bus
// - Frame asserted from start while more wanted
// - Frame deasserted marks the last data phase
// - Strobes driven high one clock, then released
// - Initiator ready means write data or read acceptance
// - Initiator ready held until data phase completes
// - Target ready means write taken or read valid
// - Target ready held until data phase completes
`timescale 1ns/1ps
module spbs_fifo #(
  parameter int W     = 36,
  parameter int DEPTH = 32
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;

  assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) ||
                     (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : spbs_fifo

module spbs_bridge_end (
  spbs_if.bridge      bus,
  input  wire logic   gnt_n,
  input  wire logic   cmd_valid,
  output logic        cmd_ready,
  input  wire logic   cmd_write,
  input  wire logic   cmd_dual,
  input  wire logic [3:0]  cmd_code,
  input  wire logic [63:0] cmd_addr,
  input  wire logic [5:0]  cmd_len,
  input  wire logic [3:0]  cmd_be_n,
  input  wire logic   wr_valid,
  output logic        wr_ready,
  input  wire logic [35:0] wr_data,
  output logic        rd_valid,
  output logic [31:0] rd_data,
  output logic        perr
);
  spbs_pkg::spbs_br_state_e state;
  logic        is_wr;
  logic        dual;
  logic [3:0]  cmd;
  logic [31:0] addr_hi;
  logic [3:0]  be_n;
  logic [5:0]  remain;
  logic        f_valid;
  logic        f_take;
  logic [35:0] f_data;
  logic        bus_idle;
  logic        start;
  logic        xfer;
  logic        addr_last;
  logic [5:0]  left;
  logic        load_w;
  logic        chk_pend;
  logic        chk_par;

  spbs_fifo #(.W(spbs_pkg::WORD_W), .DEPTH(spbs_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys   (bus.clk_sys),
    .reset_n   (bus.reset_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (f_take),
    .out_data  (f_data)
  );

  assign bus_idle  = bus.frame_n && bus.irdy_n;
  assign cmd_ready = (state == spbs_pkg::SPBS_BR_IDLE) && !gnt_n && bus_idle;
  assign start     = cmd_valid && cmd_ready;
  // Both readies low at this edge move one word
  assign xfer      = (state == spbs_pkg::SPBS_BR_DATA) &&
                     !bus.irdy_n && !bus.trdy_n;
  assign addr_last = (state == spbs_pkg::SPBS_BR_ADDR2) ||
                     (state == spbs_pkg::SPBS_BR_ADDR && !dual);
  assign left      = remain - {5'h00, xfer};
  // New write word only when no word is pending
  assign load_w    = (state == spbs_pkg::SPBS_BR_DATA) && is_wr &&
                     f_valid && (bus.br_irdy_n_o || xfer) && (left != 6'h00);
  assign f_take    = load_w;

  always_ff @(posedge bus.clk_sys) begin
    if (!bus.reset_n) begin
      state            <= spbs_pkg::SPBS_BR_IDLE;
      is_wr            <= 1'b0;
      dual             <= 1'b0;
      cmd              <= spbs_pkg::RESET_CBE;
      addr_hi          <= spbs_pkg::RESET_AD;
      be_n             <= spbs_pkg::RESET_CBE;
      remain           <= 6'h00;
      bus.br_ad_o      <= spbs_pkg::RESET_AD;
      bus.br_ad_oe     <= 1'b0;
      bus.br_cbe_n_o   <= spbs_pkg::RESET_CBE;
      bus.br_cbe_oe    <= 1'b0;
      bus.br_frame_n_o <= 1'b1;
      bus.br_frame_oe  <= 1'b0;
      bus.br_irdy_n_o  <= 1'b1;
      bus.br_irdy_oe   <= 1'b0;
    end else begin
      unique case (state)
        spbs_pkg::SPBS_BR_IDLE: begin
          if (start) begin
            is_wr            <= cmd_write;
            dual             <= cmd_dual;
            cmd              <= cmd_code;
            addr_hi          <= cmd_addr[63:32];
            be_n             <= cmd_be_n;
            remain           <= (cmd_len == 6'h00) ? 6'h01 : cmd_len;
            bus.br_ad_o      <= cmd_addr[31:0];
            bus.br_ad_oe     <= 1'b1;
            bus.br_cbe_n_o   <= cmd_dual ? spbs_pkg::CMD_DUAL
                                         : cmd_code;
            bus.br_cbe_oe    <= 1'b1;
            bus.br_frame_n_o <= 1'b0;
            bus.br_frame_oe  <= 1'b1;
            bus.br_irdy_n_o  <= 1'b1;
            bus.br_irdy_oe   <= 1'b1;
            state            <= spbs_pkg::SPBS_BR_ADDR;
          end else begin
            // Park so the bus never floats while we own it
            bus.br_ad_o    <= spbs_pkg::PARK_AD;
            bus.br_cbe_n_o <= spbs_pkg::PARK_CBE;
            bus.br_ad_oe   <= !gnt_n && bus_idle;
            bus.br_cbe_oe  <= !gnt_n && bus_idle;
          end
        end
        spbs_pkg::SPBS_BR_ADDR: begin
          if (dual) begin
            bus.br_ad_o    <= addr_hi;
            bus.br_cbe_n_o <= cmd;
            state          <= spbs_pkg::SPBS_BR_ADDR2;
          end
        end
        spbs_pkg::SPBS_BR_ADDR2: begin
        end
        spbs_pkg::SPBS_BR_DATA: begin
          if (xfer && remain == 6'h01) begin
            bus.br_irdy_n_o <= 1'b1;
            bus.br_ad_oe    <= 1'b0;
            bus.br_cbe_oe   <= 1'b0;
            state           <= spbs_pkg::SPBS_BR_REL;
          end else if (is_wr) begin
            if (load_w) begin
              bus.br_ad_o      <= f_data[31:0];
              bus.br_cbe_n_o   <= f_data[35:32];
              bus.br_irdy_n_o  <= 1'b0;
              bus.br_frame_n_o <= (left == 6'h01);
            end else if (xfer) begin
              bus.br_irdy_n_o <= 1'b1;
            end
          end else if (xfer && remain == 6'h02) begin
            bus.br_frame_n_o <= 1'b1;
          end
          if (xfer) begin
            remain <= left;
          end
        end
        spbs_pkg::SPBS_BR_REL: begin
          bus.br_frame_oe <= 1'b0;
          bus.br_irdy_oe  <= 1'b0;
          state           <= spbs_pkg::SPBS_BR_IDLE;
        end
      endcase
      if (addr_last) begin
        state <= spbs_pkg::SPBS_BR_DATA;
        if (!is_wr) begin
          // Read: hand the data lines over, accept at once
          bus.br_ad_oe     <= 1'b0;
          bus.br_cbe_n_o   <= be_n;
          bus.br_irdy_n_o  <= 1'b0;
          bus.br_frame_n_o <= (remain == 6'h01);
        end
      end
    end
  end

  // Parity trails its data and its release by one clock
  always_ff @(posedge bus.clk_sys) begin
    if (!bus.reset_n) begin
      bus.br_par_o  <= 1'b0;
      bus.br_par_oe <= 1'b0;
    end else begin
      bus.br_par_o  <= spbs_pkg::spbs_even_par(bus.br_ad_o,
                                               bus.br_cbe_n_o);
      bus.br_par_oe <= bus.br_ad_oe;
    end
  end

  always_ff @(posedge bus.clk_sys) begin
    if (!bus.reset_n) begin
      rd_valid <= 1'b0;
      rd_data  <= spbs_pkg::RESET_AD;
      chk_pend <= 1'b0;
      chk_par  <= 1'b0;
      perr     <= 1'b0;
    end else begin
      rd_valid <= xfer && !is_wr;
      if (xfer && !is_wr) begin
        rd_data <= bus.ad;
      end
      chk_pend <= xfer && !is_wr;
      chk_par  <= spbs_pkg::spbs_even_par(bus.ad, bus.cbe_n);
      perr     <= chk_pend && (chk_par != bus.par);
    end
  end
endmodule : spbs_bridge_end

// File: spbs_pkg.sv
package spbs_pkg;
  localparam int AD_W       = 32;
  localparam int CBE_W      = 4;
  localparam int LEN_W      = 6;
  localparam int WORD_W     = AD_W + CBE_W;
  localparam int FIFO_DEPTH = 32;

  localparam logic [3:0]  CMD_DUAL  = 4'hd;
  localparam logic [31:0] PARK_AD   = 32'h0000_0000;
  localparam logic [3:0]  PARK_CBE  = 4'h0;
  localparam logic [31:0] RESET_AD  = 32'h0000_0000;
  localparam logic [3:0]  RESET_CBE = 4'hf;
  localparam logic [31:0] PULL_AD   = 32'hffff_ffff;
  localparam logic [3:0]  PULL_CBE  = 4'hf;

  typedef enum logic [2:0] {
    SPBS_BR_IDLE, SPBS_BR_ADDR, SPBS_BR_ADDR2, SPBS_BR_DATA, SPBS_BR_REL
  } spbs_br_state_e;

  typedef enum logic [2:0] {
    SPBS_AG_IDLE, SPBS_AG_ADDR2, SPBS_AG_TURN, SPBS_AG_DATA, SPBS_AG_REL
  } spbs_ag_state_e;

  // Even parity: the 36 bits plus this bit hold an even number of ones
  function automatic logic spbs_even_par(input logic [31:0] ad,
                                         input logic [3:0]  cbe);
    return ^{ad, cbe};
  endfunction : spbs_even_par
endpackage : spbs_pkg

// File: spbs_if.sv
`timescale 1ns/1ps
interface spbs_if (
  input wire logic clk_sys,
  input wire logic reset_n
);
  logic [31:0] br_ad_o;
  logic        br_ad_oe;
  logic [3:0]  br_cbe_n_o;
  logic        br_cbe_oe;
  logic        br_par_o;
  logic        br_par_oe;
  logic        br_frame_n_o;
  logic        br_frame_oe;
  logic        br_irdy_n_o;
  logic        br_irdy_oe;
  logic [31:0] ag_ad_o;
  logic        ag_ad_oe;
  logic        ag_par_o;
  logic        ag_par_oe;
  logic        ag_trdy_n_o;
  logic        ag_trdy_oe;

  logic [31:0] ad;
  logic [3:0]  cbe_n;
  logic        par;
  logic        frame_n;
  logic        irdy_n;
  logic        trdy_n;

  // Undriven lines read as the pull-up level
  always_comb begin
    ad      = br_ad_oe ? br_ad_o : (ag_ad_oe ? ag_ad_o : spbs_pkg::PULL_AD);
    cbe_n   = br_cbe_oe ? br_cbe_n_o : spbs_pkg::PULL_CBE;
    par     = br_par_oe ? br_par_o : (ag_par_oe ? ag_par_o : 1'b1);
    frame_n = br_frame_oe ? br_frame_n_o : 1'b1;
    irdy_n  = br_irdy_oe ? br_irdy_n_o : 1'b1;
    trdy_n  = ag_trdy_oe ? ag_trdy_n_o : 1'b1;
  end

  modport bridge (
    input  clk_sys, reset_n, ad, cbe_n, par, frame_n, irdy_n, trdy_n,
    output br_ad_o, br_ad_oe, br_cbe_n_o, br_cbe_oe, br_par_o, br_par_oe,
    output br_frame_n_o, br_frame_oe, br_irdy_n_o, br_irdy_oe
  );

  modport agent (
    input  clk_sys, reset_n, ad, cbe_n, par, frame_n, irdy_n, trdy_n,
    output ag_ad_o, ag_ad_oe, ag_par_o, ag_par_oe, ag_trdy_n_o, ag_trdy_oe
  );
endinterface : spbs_if

// File: spbs_agent_end.sv
`timescale 1ns/1ps
module spbs_agent_end (
  spbs_if.agent       bus,
  input  wire logic   sink_ready,
  output logic        wr_valid,
  output logic [31:0] wr_data,
  output logic [3:0]  wr_be_n,
  input  wire logic   rd_avail,
  input  wire logic [31:0] rd_word,
  output logic        rd_take,
  output logic [63:0] addr,
  output logic [3:0]  cmd,
  output logic        perr
);
  spbs_pkg::spbs_ag_state_e state;
  logic frame_prev;
  logic is_wr;
  logic addr_seen;
  logic xfer;
  logic last;
  logic chk_pend;
  logic chk_par;

  assign addr_seen = (state == spbs_pkg::SPBS_AG_IDLE) && !bus.frame_n &&
                     frame_prev;
  assign xfer      = (state == spbs_pkg::SPBS_AG_DATA) && !bus.irdy_n &&
                     !bus.ag_trdy_n_o;
  assign last      = xfer && bus.frame_n;
  // Next read word only when none is pending
  assign rd_take   = !is_wr && rd_avail && !last &&
                     (state == spbs_pkg::SPBS_AG_TURN ||
                      state == spbs_pkg::SPBS_AG_DATA) &&
                     (bus.ag_trdy_n_o || xfer);

  always_ff @(posedge bus.clk_sys) begin
    if (!bus.reset_n) begin
      state           <= spbs_pkg::SPBS_AG_IDLE;
      frame_prev      <= 1'b1;
      is_wr           <= 1'b0;
      addr            <= 64'h0000_0000_0000_0000;
      cmd             <= spbs_pkg::RESET_CBE;
      bus.ag_ad_o     <= spbs_pkg::RESET_AD;
      bus.ag_ad_oe    <= 1'b0;
      bus.ag_trdy_n_o <= 1'b1;
      bus.ag_trdy_oe  <= 1'b0;
    end else begin
      frame_prev <= bus.frame_n;
      unique case (state)
        spbs_pkg::SPBS_AG_IDLE: begin
          if (addr_seen) begin
            addr <= {32'h0000_0000, bus.ad};
            cmd  <= bus.cbe_n;
            if (bus.cbe_n == spbs_pkg::CMD_DUAL) begin
              state <= spbs_pkg::SPBS_AG_ADDR2;
            end else begin
              is_wr          <= bus.cbe_n[0];
              bus.ag_trdy_oe <= 1'b1;
              state          <= bus.cbe_n[0] ? spbs_pkg::SPBS_AG_DATA
                                             : spbs_pkg::SPBS_AG_TURN;
            end
          end
        end
        spbs_pkg::SPBS_AG_ADDR2: begin
          addr[63:32]    <= bus.ad;
          cmd            <= bus.cbe_n;
          is_wr          <= bus.cbe_n[0];
          bus.ag_trdy_oe <= 1'b1;
          state          <= bus.cbe_n[0] ? spbs_pkg::SPBS_AG_DATA
                                         : spbs_pkg::SPBS_AG_TURN;
        end
        spbs_pkg::SPBS_AG_TURN: begin
          // Turnaround clock lets the initiator drop the lines first
          bus.ag_ad_oe <= 1'b1;
          state        <= spbs_pkg::SPBS_AG_DATA;
        end
        spbs_pkg::SPBS_AG_DATA: begin
          if (last) begin
            bus.ag_trdy_n_o <= 1'b1;
            bus.ag_ad_oe    <= 1'b0;
            state           <= spbs_pkg::SPBS_AG_REL;
          end else if (is_wr && (bus.ag_trdy_n_o || xfer)) begin
            bus.ag_trdy_n_o <= !sink_ready;
          end else if (!is_wr && xfer && !rd_take) begin
            bus.ag_trdy_n_o <= 1'b1;
          end
        end
        spbs_pkg::SPBS_AG_REL: begin
          bus.ag_trdy_oe <= 1'b0;
          state          <= spbs_pkg::SPBS_AG_IDLE;
        end
      endcase
      if (rd_take) begin
        bus.ag_ad_o     <= rd_word;
        bus.ag_trdy_n_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge bus.clk_sys) begin
    if (!bus.reset_n) begin
      bus.ag_par_o  <= 1'b0;
      bus.ag_par_oe <= 1'b0;
    end else begin
      bus.ag_par_o  <= spbs_pkg::spbs_even_par(bus.ag_ad_o,
                                               bus.cbe_n);
      bus.ag_par_oe <= bus.ag_ad_oe;
    end
  end

  always_ff @(posedge bus.clk_sys) begin
    if (!bus.reset_n) begin
      wr_valid <= 1'b0;
      wr_data  <= spbs_pkg::RESET_AD;
      wr_be_n  <= spbs_pkg::RESET_CBE;
      chk_pend <= 1'b0;
      chk_par  <= 1'b0;
      perr     <= 1'b0;
    end else begin
      wr_valid <= xfer && is_wr;
      if (xfer && is_wr) begin
        wr_data <= bus.ad;
        wr_be_n <= bus.cbe_n;
      end
      chk_pend <= addr_seen || (state == spbs_pkg::SPBS_AG_ADDR2) ||
                  (xfer && is_wr);
      chk_par  <= spbs_pkg::spbs_even_par(bus.ad, bus.cbe_n);
      perr     <= chk_pend && (chk_par != bus.par);
    end
  end
endmodule : spbs_agent_end

// File: spbs_monitor.sv
`timescale 1ns/1ps
module spbs_monitor (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        br_ad_oe,
  input wire logic        br_cbe_oe,
  input wire logic        br_par_o,
  input wire logic        br_par_oe,
  input wire logic        br_frame_n_o,
  input wire logic        br_frame_oe,
  input wire logic        br_irdy_n_o,
  input wire logic        br_irdy_oe,
  input wire logic        ag_ad_oe,
  input wire logic        ag_par_o,
  input wire logic        ag_par_oe,
  input wire logic        ag_trdy_n_o,
  input wire logic        ag_trdy_oe,
  input wire logic [31:0] ad,
  input wire logic [3:0]  cbe_n,
  input wire logic        frame_n,
  input wire logic        irdy_n,
  input wire logic        trdy_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Past reset term keeps a short reset from firing on stale enables
  property p_bpo;
    br_par_oe == ($past(br_ad_oe) && $past(reset_n));
  endproperty
  a_bpo: assert property (p_bpo) else $error("bridge par enable");
  property p_bpv;
    br_par_oe |-> br_par_o == ^{$past(ad), $past(cbe_n)};
  endproperty
  a_bpv: assert property (p_bpv) else $error("bridge par value");
  property p_apo;
    ag_par_oe == ($past(ag_ad_oe) && $past(reset_n));
  endproperty
  a_apo: assert property (p_apo) else $error("agent par enable");
  property p_apv;
    ag_par_oe |-> ag_par_o == ^{$past(ad), $past(cbe_n)};
  endproperty
  a_apv: assert property (p_apv) else $error("agent par value");
  property p_ihold;
    !irdy_n && trdy_n |=> !irdy_n;
  endproperty
  a_ihold: assert property (p_ihold) else $error("irdy dropped");
  property p_thold;
    !trdy_n && irdy_n |=> !trdy_n;
  endproperty
  a_thold: assert property (p_thold) else $error("trdy dropped");
  property p_irel;
    $fell(br_irdy_oe) && $past(reset_n) |-> $past(br_irdy_n_o);
  endproperty
  a_irel: assert property (p_irel) else $error("irdy release");
  property p_frel;
    $fell(br_frame_oe) && $past(reset_n) |-> $past(br_frame_n_o);
  endproperty
  a_frel: assert property (p_frel) else $error("frame release");
  property p_trel;
    $fell(ag_trdy_oe) && $past(reset_n) |-> $past(ag_trdy_n_o);
  endproperty
  a_trel: assert property (p_trel) else $error("trdy release");
  property p_last;
    $rose(frame_n) && $past(reset_n) |-> !irdy_n;
  endproperty
  a_last: assert property (p_last) else $error("frame end");
  property p_one;
    !(br_ad_oe && ag_ad_oe);
  endproperty
  a_one: assert property (p_one) else $error("ad contention");
  property p_start;
    $fell(frame_n) |-> br_ad_oe && br_cbe_oe;
  endproperty
  a_start: assert property (p_start) else $error("addr phase");
  property p_done;
    $fell(frame_n) |-> ##[1:200] !irdy_n && !trdy_n;
  endproperty
  a_done: assert property (p_done) else $error("no transfer");
  property p_wst;
    !irdy_n && trdy_n && br_ad_oe |=> $stable(ad);
  endproperty
  a_wst: assert property (p_wst) else $error("write data moved");
  property p_rdv;
    !trdy_n && !br_ad_oe |-> ag_ad_oe;
  endproperty
  a_rdv: assert property (p_rdv) else $error("read data undriven");
endmodule : spbs_monitor

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int LIMIT = 20000;
  logic        clk_sys;
  logic        reset_n;
  logic        gnt_n;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_write;
  logic        cmd_dual;
  logic [3:0]  cmd_code;
  logic [63:0] cmd_addr;
  logic [5:0]  cmd_len;
  logic [3:0]  cmd_be_n;
  logic [3:0]  rd_be;
  logic        wr_valid;
  logic        wr_ready;
  logic [35:0] wr_data;
  logic        rd_valid;
  logic [31:0] rd_data;
  logic        br_perr;
  logic        sink_ready;
  logic        ag_wr_valid;
  logic [31:0] ag_wr_data;
  logic [3:0]  ag_wr_be_n;
  logic        rd_avail;
  logic [31:0] rd_word;
  logic        rd_take;
  logic [63:0] ag_addr;
  logic [3:0]  ag_cmd;
  logic        ag_perr;
  logic        f_perr;
  logic        stall;
  logic        fr_d;
  logic        st1;
  logic [3:0]  ph1;
  logic [3:0]  ph2;
  logic [31:0] ph_ad;
  logic [35:0] ag_q[$];
  logic [31:0] rd_q[$];
  int          cyc;
  int          n_perr;
  int          n_fperr;
  int          n_mismatch;
  int          cmp_count;

  spbs_if i_spbs_if (.clk_sys(clk_sys), .reset_n(reset_n));
  spbs_if i_flt_if (.clk_sys(clk_sys), .reset_n(reset_n));
  spbs_bridge_end i_spbs_bridge_end (.bus(i_spbs_if), .gnt_n(gnt_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_dual(cmd_dual), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .cmd_be_n(cmd_be_n), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .perr(br_perr));
  spbs_agent_end i_spbs_agent_end (.bus(i_spbs_if), .sink_ready(sink_ready),
    .wr_valid(ag_wr_valid), .wr_data(ag_wr_data), .wr_be_n(ag_wr_be_n),
    .rd_avail(rd_avail), .rd_word(rd_word), .rd_take(rd_take),
    .addr(ag_addr), .cmd(ag_cmd), .perr(ag_perr));
  // Second agent faces a hand-driven initiator that sends bad parity
  spbs_agent_end i_spbs_agent_end_flt (.bus(i_flt_if), .sink_ready(1'b1),
    .wr_valid(), .wr_data(), .wr_be_n(), .rd_avail(1'b0), .rd_word(32'h0),
    .rd_take(), .addr(), .cmd(), .perr(f_perr));
  spbs_monitor i_spbs_monitor (.clk_sys(clk_sys), .reset_n(reset_n),
    .br_ad_oe(i_spbs_if.br_ad_oe), .br_cbe_oe(i_spbs_if.br_cbe_oe),
    .br_par_o(i_spbs_if.br_par_o), .br_par_oe(i_spbs_if.br_par_oe),
    .br_frame_n_o(i_spbs_if.br_frame_n_o),
    .br_frame_oe(i_spbs_if.br_frame_oe),
    .br_irdy_n_o(i_spbs_if.br_irdy_n_o), .br_irdy_oe(i_spbs_if.br_irdy_oe),
    .ag_ad_oe(i_spbs_if.ag_ad_oe), .ag_par_o(i_spbs_if.ag_par_o),
    .ag_par_oe(i_spbs_if.ag_par_oe), .ag_trdy_n_o(i_spbs_if.ag_trdy_n_o),
    .ag_trdy_oe(i_spbs_if.ag_trdy_oe), .ad(i_spbs_if.ad),
    .cbe_n(i_spbs_if.cbe_n), .frame_n(i_spbs_if.frame_n),
    .irdy_n(i_spbs_if.irdy_n), .trdy_n(i_spbs_if.trdy_n));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic chk_val(input string nm, input logic [63:0] e,
                         input logic [63:0] s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_val

  task automatic chk_bit(input string nm, input logic e, input logic s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, e, s);
    end
  endtask : chk_bit

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  function automatic logic [35:0] wword(input int i);
    return {4'(i), 32'h5a00_0000 + 32'(i)};
  endfunction : wword

  // Valid stays up across the burst so it is never set twice in a step
  task automatic push_burst(input int n);
    for (int i = 0; i < n; i++) begin
      wr_valid <= 1'b1;
      wr_data  <= wword(i);
      do @(posedge clk_sys); while (wr_ready !== 1'b1);
    end
    wr_valid <= 1'b0;
  endtask : push_burst

  task automatic issue(input logic w, input logic d, input logic [3:0] c,
                       input logic [63:0] a, input logic [5:0] n);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_dual  <= d;
    cmd_code  <= c;
    cmd_addr  <= a;
    cmd_len   <= n;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
  endtask : issue

  task automatic flt(input logic oe, input logic poe, input logic soe,
                     input logic [31:0] a, input logic [3:0] c,
                     input logic p, input logic fn, input logic in);
    i_flt_if.br_ad_oe     <= oe;
    i_flt_if.br_cbe_oe    <= oe;
    i_flt_if.br_ad_o      <= a;
    i_flt_if.br_cbe_n_o   <= c;
    i_flt_if.br_par_oe    <= poe;
    i_flt_if.br_par_o     <= p;
    i_flt_if.br_frame_oe  <= soe;
    i_flt_if.br_irdy_oe   <= soe;
    i_flt_if.br_frame_n_o <= fn;
    i_flt_if.br_irdy_n_o  <= in;
  endtask : flt

  always @(posedge clk_sys) begin
    cyc  <= cyc + 1;
    fr_d <= i_spbs_if.frame_n;
    st1  <= fr_d && !i_spbs_if.frame_n;
    if (fr_d && !i_spbs_if.frame_n) begin
      ph1   <= i_spbs_if.cbe_n;
      ph_ad <= i_spbs_if.ad;
    end
    if (st1)
      ph2 <= i_spbs_if.cbe_n;
    // Byte enables seen on a read word as it moves
    if (!i_spbs_if.irdy_n && !i_spbs_if.trdy_n &&
        i_spbs_if.br_ad_oe === 1'b0)
      rd_be <= i_spbs_if.cbe_n;
    if (ag_wr_valid === 1'b1)
      ag_q.push_back({ag_wr_be_n, ag_wr_data});
    if (rd_valid === 1'b1)
      rd_q.push_back(rd_data);
    if (rd_take === 1'b1)
      rd_word <= rd_word + 32'h1;
    if (br_perr === 1'b1 || ag_perr === 1'b1)
      n_perr++;
    if (f_perr === 1'b1)
      n_fperr++;
    sink_ready <= !stall || cyc[1:0] != 2'h0;
    rd_avail   <= !stall || cyc[0];
    if (cyc == LIMIT) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    reset_n    <= 1'b0;
    gnt_n      <= 1'b0;
    cmd_valid  <= 1'b0;
    cmd_write  <= 1'b0;
    cmd_dual   <= 1'b0;
    cmd_code   <= 4'h0;
    cmd_addr   <= 64'h0;
    cmd_len    <= 6'h0;
    cmd_be_n   <= 4'h0;
    wr_valid   <= 1'b0;
    wr_data    <= 36'h0;
    stall      <= 1'b0;
    sink_ready <= 1'b1;
    rd_avail   <= 1'b1;
    rd_word    <= 32'hc0de_0000;
    flt(1'b0, 1'b0, 1'b0, 32'h0, 4'h0, 1'b1, 1'b1, 1'b1);
    tick(20);
    reset_n <= 1'b1;
    tick(6);
    @(negedge clk_sys);
    chk_val("park ad", spbs_pkg::PARK_AD, i_spbs_if.ad);
    chk_val("park cbe", spbs_pkg::PARK_CBE, i_spbs_if.cbe_n);
    chk_bit("park par", ^{spbs_pkg::PARK_AD, spbs_pkg::PARK_CBE},
            i_spbs_if.par);
    @(posedge clk_sys);
    gnt_n <= 1'b1;
    tick(6);
    @(negedge clk_sys);
    chk_bit("unpark", 1'b0, i_spbs_if.br_ad_oe);
    @(posedge clk_sys);
    gnt_n <= 1'b0;
    $display("test park done");
    stall <= 1'b1;
    push_burst(32);
    @(negedge clk_sys);
    chk_bit("fifo full", 1'b0, wr_ready);
    @(posedge clk_sys);
    issue(1'b1, 1'b0, 4'h7, 64'h4000, 6'h20);
    while (ag_q.size() < 32) @(posedge clk_sys);
    tick(4);
    chk_val("wr addr", 64'h4000, ag_addr);
    chk_val("wr cmd", 4'h7, ag_cmd);
    chk_val("wr ph ad", 32'h4000, ph_ad);
    chk_val("wr ph cmd", 4'h7, ph1);
    chk_val("wr count", 32, ag_q.size());
    for (int i = 0; i < 32; i++)
      chk_val("wr word", wword(i), ag_q[i]);
    chk_bit("fifo drained", 1'b1, wr_ready);
    $display("test write done");
    cmd_be_n <= 4'h3;
    issue(1'b0, 1'b1, 4'h6, 64'h0000_0001_2345_6780, 6'h04);
    while (rd_q.size() < 4) @(posedge clk_sys);
    tick(4);
    chk_val("rd addr", 64'h0000_0001_2345_6780, ag_addr);
    chk_val("rd ph1", spbs_pkg::CMD_DUAL, ph1);
    chk_val("rd ph2", 4'h6, ph2);
    chk_val("rd cmd", 4'h6, ag_cmd);
    for (int i = 0; i < 4; i++)
      chk_val("rd word", 32'hc0de_0000 + 32'(i), rd_q[i]);
    chk_val("rd be", 4'h3, rd_be);
    $display("test read done");
    stall <= 1'b0;
    ag_q.delete();
    push_burst(1);
    issue(1'b1, 1'b1, 4'h7, 64'h0000_0002_0000_4100, 6'h00);
    tick(30);
    chk_val("len0 count", 1, ag_q.size());
    chk_val("len0 word", wword(0), ag_q[0]);
    chk_val("len0 addr", 64'h0000_0002_0000_4100, ag_addr);
    chk_bit("no perr", 1'b0, n_perr != 0);
    $display("test short done");
    @(posedge clk_sys);
    flt(1'b1, 1'b0, 1'b1, 32'h8000, 4'h7, 1'b1, 1'b0, 1'b1);
    @(posedge clk_sys);
    flt(1'b1, 1'b1, 1'b1, 32'h1234_5678, 4'h0, ~^{32'h8000, 4'h7},
        1'b1, 1'b0);
    @(posedge clk_sys);
    flt(1'b1, 1'b1, 1'b1, 32'h1234_5678, 4'h0, ^{32'h1234_5678, 4'h0},
        1'b1, 1'b0);
    while (i_flt_if.trdy_n !== 1'b0) @(posedge clk_sys);
    flt(1'b0, 1'b1, 1'b1, 32'h0, 4'h0, ^{32'h1234_5678, 4'h0}, 1'b1, 1'b1);
    @(posedge clk_sys);
    flt(1'b0, 1'b0, 1'b0, 32'h0, 4'h0, 1'b1, 1'b1, 1'b1);
    tick(8);
    chk_bit("addr perr", 1'b1, n_fperr > 0);
    $display("test fault done");
    summarize();
  end
endmodule : tb_top
